/* rtl/cis_ctrl.sv */
// Purpose: comparator input select, short, filter and pin buffer disable registers
// Assumes: comparator output arrives asynchronously; APB master well behaved
// Notes:   zero-wait APB slave; unmapped addresses read zero and raise pslverr
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "cis_map.svh"
// Functional notes
// - short bit set ties plus and minus comparator inputs together.
// - two-bit select routes channels 0 to 2 to plus, minus when exchanged.
// - three-bit select routes channels 1 to 7 to minus, plus when exchanged.
// - filter bit chooses filtered or unfiltered comparator result.
// - each pin disable bit set turns off one digital input buffer.
// - pin disable bit n serves the pin of analog channel n.
// - exchange bit swaps plus and minus inputs and inverts the output.
module cis_ctrl (
  // apb clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // analog front end
  input  wire logic               comp_raw,
  output logic                    input_short_en,
  output cis_pkg::cis_byte_type   plus_connect,
  output cis_pkg::cis_byte_type   minus_connect,
  output logic                    output_filter_en,
  output logic                    input_exchange,
  output logic                    comparator_result,
  output cis_pkg::cis_byte_type   pin_buffer_disable
);
  import cis_pkg::*;

  cis_byte_type    ctl2_r;
  cis_byte_type    pbd_r;
  logic            xch_r;
  logic            sync1_r;
  logic            sync2_r;
  logic            filt;
  logic            polar;
  logic            wr;
  logic            rd;
  logic            hit;
  cis_pos_sel_type pos_code;
  cis_neg_sel_type neg_code;
  logic [7:0]      pos_onehot;
  logic [7:0]      neg_onehot;

  // decode of a select code into one-hot channel lines, code 0 is no connection
  function automatic logic [7:0] cis_decode(input logic [2:0] code, input logic [2:0] base);
    logic [7:0] v;
    v = 8'h00;
    if (code != 3'h0) v[code + base - 3'h1] = 1'b1;
    return v;
  endfunction

  // two stages before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= comp_raw;
      sync2_r <= sync1_r;
    end
  end

  cis_filter u_filter (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw      (sync2_r),
    .filtered (filt)
  );

  // only byte lane 0 holds implemented bits, so its strobe alone gates a write
  assign wr  = psel && penable && pwrite && pstrb[0];
  assign rd  = psel && !pwrite;
  assign hit = (paddr == `CIS_CTL2_OFF) || (paddr == `CIS_PBD_OFF) ||
               (paddr == `CIS_XCH_OFF);

  // control byte; result bit kept zero so writes there do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_r <= `CIS_CTL2_RST;
    end else if (wr && paddr == `CIS_CTL2_OFF) begin
      ctl2_r <= {pwdata[7:1], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pbd_r <= `CIS_PBD_RST;
    end else if (wr && paddr == `CIS_PBD_OFF) begin
      pbd_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xch_r <= `CIS_XCH_RST;
    end else if (wr && paddr == `CIS_XCH_OFF) begin
      xch_r <= pwdata[0];
    end
  end

  // result: filtered or raw, then inverted under exchange
  assign polar = ctl2_r[`CIS_FILT_BIT] ? filt : sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_result <= 1'b0;
    end else begin
      comparator_result <= polar ^ xch_r;
    end
  end

  assign pos_code   = {ctl2_r[`CIS_POS_HI_BIT], ctl2_r[`CIS_POS_LO_BIT]};
  assign neg_code   = ctl2_r[`CIS_NEG_MSB:`CIS_NEG_LSB];
  assign pos_onehot = cis_decode({1'b0, pos_code}, 3'h0);
  assign neg_onehot = cis_decode(neg_code, 3'h1);

  // routing outputs from flops
  // exchange swaps the decoded buses, so the decoders never see the exchange bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plus_connect   <= 8'h00;
      minus_connect  <= 8'h00;
      input_short_en <= 1'b0;
      output_filter_en <= 1'b0;
      input_exchange <= 1'b0;
      pin_buffer_disable <= 8'h00;
    end else begin
      plus_connect   <= xch_r ? neg_onehot : pos_onehot;
      minus_connect  <= xch_r ? pos_onehot : neg_onehot;
      input_short_en <= ctl2_r[`CIS_SHORT_BIT];
      output_filter_en <= ctl2_r[`CIS_FILT_BIT];
      input_exchange <= xch_r;
      pin_buffer_disable <= pbd_r;
    end
  end

  // read data registered in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `CIS_CTL2_OFF: prdata <= {24'h00_0000, ctl2_r[7:1], comparator_result};
        `CIS_PBD_OFF:  prdata <= {24'h00_0000, pbd_r};
        `CIS_XCH_OFF:  prdata <= {31'h0000_0000, xch_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // read data is flopped in setup, so no wait state is ever needed
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // every checked output is flopped, so each check looks one or two edges past its cause
  short_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CIS_CTL2_OFF) |=>
      ##1 (input_short_en == $past(pwdata[`CIS_SHORT_BIT], 2)))
    else $error("short output does not follow write");
  result_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl2_r[`CIS_RES_BIT] == 1'b0) else $error("result bit stored");

  pos_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(xch_r) && $past(pos_code) == 2'h1) |-> plus_connect == 8'h01)
    else $error("plus routing wrong");
  pos_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(xch_r) && $past(pos_code) == 2'h0) |-> plus_connect == 8'h00)
    else $error("plus connected with code zero");
  neg_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(xch_r) && $past(neg_code) == 3'h7) |-> minus_connect == 8'h80)
    else $error("minus routing wrong");
  neg_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(xch_r) && $past(neg_code) == 3'h0) |-> minus_connect == 8'h00)
    else $error("minus connected with code zero");
  swap_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(xch_r) |-> plus_connect == $past(neg_onehot))
    else $error("exchange routing wrong");
  swap_minus_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(xch_r) |-> minus_connect == $past(pos_onehot))
    else $error("exchange minus routing wrong");

  raw_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(ctl2_r[`CIS_FILT_BIT]) && !$past(xch_r)) |->
      comparator_result == $past(sync2_r))
    else $error("unfiltered result wrong");
  filt_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(ctl2_r[`CIS_FILT_BIT]) && !$past(xch_r)) |->
      comparator_result == $past(filt))
    else $error("filtered result wrong");
  out_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (!$past(ctl2_r[`CIS_FILT_BIT]) && $past(xch_r)) |->
      comparator_result == !$past(sync2_r))
    else $error("exchanged result not inverted");

  pbd_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CIS_PBD_OFF) |=> ##1 pin_buffer_disable == $past(pwdata[7:0], 2))
    else $error("pin disable mismatch");
  read_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !penable && paddr == `CIS_CTL2_OFF) |=> prdata[0] == $past(comparator_result))
    else $error("result readback wrong");
  read_pbd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !penable && paddr == `CIS_PBD_OFF) |=> prdata[7:0] == $past(pbd_r))
    else $error("pin disable readback wrong");

  short_c: cover property (@(posedge pclk) disable iff (!presetn) input_short_en);
  swap_c: cover property (@(posedge pclk) disable iff (!presetn) input_exchange && |plus_connect);
  filt_c: cover property (@(posedge pclk) disable iff (!presetn)
    output_filter_en && $rose(comparator_result));
  pbd_c: cover property (@(posedge pclk) disable iff (!presetn) |pin_buffer_disable);
endmodule // cis_ctrl

/* rtl/cis_filter.sv */
// Purpose: output filter for the comparator result
// Assumes: input already synchronised to pclk
// Notes:   result only changes after it holds steady for a run of cycles
`timescale 1ns/1ns
`include "cis_map.svh"
module cis_filter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // data
  input  wire logic raw,
  output logic      filtered
);
  import cis_pkg::*;
  logic [2:0] run_r;

  // run length resets whenever raw agrees with the held output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r    <= 3'h0;
      filtered <= 1'b0;
    end else if (raw == filtered) begin
      run_r <= 3'h0;
    end else if (run_r == `CIS_FILT_LEN - 3'h1) begin
      run_r    <= 3'h0;
      filtered <= raw;
    end else begin
      run_r <= run_r + 3'h1;
    end
  end
endmodule // cis_filter

/* rtl/cis_map.svh */
// Purpose: register offsets, field positions and reset values of the comparator control block
// Assumes: one aligned 32-bit APB word per register
// Notes:   included by bare name
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
`define CIS_CTL2_OFF     12'h000
`define CIS_PBD_OFF      12'h004
`define CIS_XCH_OFF      12'h008
`define CIS_CTL2_RST     8'h00
`define CIS_PBD_RST      8'h00
`define CIS_XCH_RST      1'b0
`define CIS_SHORT_BIT    7
`define CIS_POS_HI_BIT   6
`define CIS_NEG_MSB      5
`define CIS_NEG_LSB      3
`define CIS_POS_LO_BIT   2
`define CIS_FILT_BIT     1
`define CIS_RES_BIT      0
`define CIS_FILT_LEN     3'h4
`endif

/* rtl/cis_pkg.sv */
// Purpose: shared types of the comparator control block
// Assumes: nothing
// Notes:   numbers live in cis_map.svh
package cis_pkg;
  typedef logic [7:0] cis_byte_type;
  typedef logic [2:0] cis_neg_sel_type;
  typedef logic [1:0] cis_pos_sel_type;
endpackage

/* test/cis_ctrl_bench.sv */
// Purpose: self-checking bench for the comparator control registers over apb
// Assumes: zero-wait slave, derived outputs settle within three edges of a write
// Notes:   result latency is synchroniser plus filter, so waits leave margin
`timescale 1ns/1ns
`include "cis_map.svh"
module cis_ctrl_bench;
  import cis_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, comp_raw = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, input_short_en, output_filter_en, input_exchange;
  logic        comparator_result, er;
  logic [7:0]  plus_connect, minus_connect, pin_buffer_disable;
  int          err_total = 0, compares = 0;
  always #5 pclk = ~pclk;
  cis_ctrl u_cis_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw),
    .input_short_en(input_short_en), .plus_connect(plus_connect),
    .minus_connect(minus_connect), .output_filter_en(output_filter_en),
    .input_exchange(input_exchange), .comparator_result(comparator_result),
    .pin_buffer_disable(pin_buffer_disable));
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held from setup until the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("MISMATCH pready expected 1 seen timeout");
      summarize();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  initial begin
    wt(10);
    presetn <= 1'b1;
    rchk("ctl2 reset", `CIS_CTL2_OFF, 32'h0);
    rchk("pbd reset", `CIS_PBD_OFF, 32'h0);
    $display("test reset done");
    apb(1'b1, `CIS_CTL2_OFF, 32'h80);
    wt(3);
    chk("short", input_short_en, 1'b1);
    // neg code i, pos code i mod 4; one-hot bit index is the channel
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CIS_CTL2_OFF, {24'h0, 1'b0, i[1], i[2:0], i[0], 2'b00});
      wt(3);
      chk("plus", plus_connect, (i % 4 == 0) ? 8'h00 : 8'h01 << (i % 4 - 1));
      chk("minus", minus_connect, (i == 0) ? 8'h00 : 8'h01 << i);
      chk("short off", input_short_en, 1'b0);
    end
    $display("test select done");
    apb(1'b1, `CIS_CTL2_OFF, 32'h0c);
    apb(1'b1, `CIS_XCH_OFF, 32'h1);
    wt(3);
    chk("xch plus", plus_connect, 8'h02);
    chk("xch minus", minus_connect, 8'h01);
    chk("xch out", input_exchange, 1'b1);
    comp_raw <= 1'b1;
    wt(10);
    chk("xch result", comparator_result, 1'b0);
    apb(1'b1, `CIS_XCH_OFF, 32'h0);
    wt(3);
    chk("plus back", plus_connect, 8'h01);
    chk("minus back", minus_connect, 8'h02);
    chk("xch out off", input_exchange, 1'b0);
    wt(4);
    chk("raw result", comparator_result, 1'b1);
    rchk("result read", `CIS_CTL2_OFF, 32'h0d);
    apb(1'b1, `CIS_CTL2_OFF, 32'h0c);
    rchk("result write", `CIS_CTL2_OFF, 32'h0d);
    comp_raw <= 1'b0;
    wt(10);
    apb(1'b1, `CIS_CTL2_OFF, 32'h8d);
    rchk("bit0 ignored", `CIS_CTL2_OFF, 32'h8c);
    $display("test exchange and result done");
    apb(1'b1, `CIS_CTL2_OFF, 32'h02);
    wt(3);
    chk("filter en", output_filter_en, 1'b1);
    comp_raw <= 1'b1;
    wt(2);
    comp_raw <= 1'b0;
    wt(12);
    chk("glitch filtered", comparator_result, 1'b0);
    comp_raw <= 1'b1;
    wt(14);
    chk("filtered high", comparator_result, 1'b1);
    $display("test filter done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CIS_PBD_OFF, 32'h1 << i);
      wt(3);
      chk("pin disable", pin_buffer_disable, 8'h01 << i);
      rchk("pbd read", `CIS_PBD_OFF, 32'h1 << i);
    end
    apb(1'b1, 12'h00c, 32'hff);
    chk("unmapped err", er, 1'b1);
    rchk("unmapped read", 12'h00c, 32'h0);
    chk("unmapped rd err", er, 1'b1);
    chk("pbd kept", pin_buffer_disable, 8'h80);
    pstrb <= 4'h0;
    apb(1'b1, `CIS_PBD_OFF, 32'h55);
    pstrb <= 4'hf;
    rchk("strb off kept", `CIS_PBD_OFF, 32'h80);
    $display("test pin disable done");
    summarize();
  end
endmodule // cis_ctrl_bench
